//--- shared/afe_pkg.sv
package afe_pkg;
  localparam int CLK_NS = 5;
  localparam int SYNC_CYC = 2;
  localparam int WORD_W = 9;
  localparam int DEPTH = 8192;
  // strobe and flag times, slowest speed grade
  localparam int STROBE_LOW_NS = 65;
  localparam int READ_ACCESS_NS = 65;
  localparam int FLAG_SETTLE_NS = 80;
  localparam int RESET_PULSE_NS = 65;
  localparam int REWIND_PULSE_NS = 65;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  // one spare cycle: read data may settle on the very edge that samples it
  localparam int READ_LOW_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC + 1;
  localparam int RECOVER_CYC = (FLAG_SETTLE_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int RESET_LOW_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int REWIND_LOW_CYC = (REWIND_PULSE_NS + CLK_NS - 1) / CLK_NS;
  // register offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] WDATA_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] RDATA_OFS = 8'h0C;
  localparam logic [7:0] CONFIG_OFS = 8'h10;
  // status and config bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_EMPTY_N = 1;
  localparam int ST_FULL_N = 2;
  localparam int ST_HALF_N = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_RDVALID = 5;
  localparam int CFG_FLOW = 0;
  localparam logic [WORD_W-1:0] WDATA_RST = 9'h000;
  typedef logic [4:0] afe_cnt_t;
  typedef enum logic [2:0] {
    AFE_OP_NONE = 3'h0,
    AFE_OP_WRITE = 3'h1,
    AFE_OP_READ = 3'h2,
    AFE_OP_RESET = 3'h3,
    AFE_OP_REWIND = 3'h4
  } afe_op_t;
  typedef enum logic [1:0] {
    AFE_SEQ_IDLE = 2'b00,
    AFE_SEQ_LOW = 2'b01,
    AFE_SEQ_HIGH = 2'b11
  } afe_seq_state_t;
endpackage

//--- shared/afe_seq_if.sv
`timescale 1ns/100ps
`default_nettype none
interface afe_seq_if;
  logic start;
  afe_pkg::afe_cnt_t low_len;
  afe_pkg::afe_cnt_t high_len;
  logic last_low;
  logic done;
  modport ctrl(output start, output low_len, output high_len, input last_low, input done);
  modport timer(input start, input low_len, input high_len, output last_low, output done);
endinterface
`default_nettype wire

//--- design/afe_seq_timer.sv
`timescale 1ns/100ps
`default_nettype none
module afe_seq_timer (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // control side
  afe_seq_if.timer seq
);
  afe_pkg::afe_seq_state_t state_r;
  afe_pkg::afe_cnt_t cnt_r;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= afe_pkg::AFE_SEQ_IDLE;
      cnt_r <= 5'h00;
    end else begin
      unique case (state_r)
        afe_pkg::AFE_SEQ_IDLE: begin
          if (seq.start) begin
            state_r <= afe_pkg::AFE_SEQ_LOW;
            cnt_r <= seq.low_len - 5'h01;
          end
        end
        afe_pkg::AFE_SEQ_LOW: begin
          if (cnt_r == 5'h00) begin
            state_r <= afe_pkg::AFE_SEQ_HIGH;
            cnt_r <= seq.high_len - 5'h01;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        afe_pkg::AFE_SEQ_HIGH: begin
          if (cnt_r == 5'h00) begin
            state_r <= afe_pkg::AFE_SEQ_IDLE;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        default: state_r <= afe_pkg::AFE_SEQ_IDLE;
      endcase
    end
  end

  assign seq.last_low = (state_r == afe_pkg::AFE_SEQ_LOW) && (cnt_r == 5'h00);
  assign seq.done = (state_r == afe_pkg::AFE_SEQ_HIGH) && (cnt_r == 5'h00);
endmodule
`default_nettype wire

//--- design/afe_host_ctrl.sv
// Contract
// - grounded chain_input selects single-device use; host holds it low
// - width expansion: all devices get identical strobes, reset and rewind
// - never tie output controls of different devices together
// - depth mode: exactly one device has first_device_select_n grounded
// - each chain_output feeds the next device's chain_input in a ring
// - depth mode composite flags assert only when all devices assert
// - each system watches full where it writes, empty where it reads
// - further writes need a write strobe toggle while full is released
// - both strobes stay high while a rewind is in progress
`timescale 1ns/100ps
`default_nettype none
module afe_host_ctrl (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // fifo device pins
  output logic [8:0] fifo_d_out,
  output logic write_strobe_n_out,
  output logic read_strobe_n_out,
  output logic reset_n_out,
  output logic rewind_strobe_n_out,
  output logic chain_input_out,
  input wire logic [8:0] fifo_q_in,
  input wire logic empty_indicator_n_in,
  input wire logic full_indicator_n_in,
  input wire logic half_full_indicator_n_in
);
  afe_seq_if seq();
  afe_seq_timer u_timer (.clk_in(clk_in), .resetn_in(resetn_in), .seq(seq));

  logic [11:0] sync1_r;
  logic [11:0] sync2_r;
  logic busy_r;
  logic flow_r;
  logic refused_r;
  logic rdvalid_r;
  afe_pkg::afe_op_t op_r;
  logic [8:0] rdata_r;
  logic empty_s;
  logic full_s;
  logic half_s;
  logic apb_take;
  logic apb_setup;
  logic cmd_wr;
  logic op_ok;
  logic refuse;
  afe_pkg::afe_op_t req_op;

  // pins pass two flops; only the second stage is read
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_r <= 12'h000;
      sync2_r <= 12'h000;
    end else begin
      sync1_r <= {half_full_indicator_n_in, full_indicator_n_in, empty_indicator_n_in, fifo_q_in};
      sync2_r <= sync1_r;
    end
  end
  // one device's flags stand for all width-expanded devices
  assign empty_s = sync2_r[9];
  assign full_s = sync2_r[10];
  assign half_s = sync2_r[11];

  assign apb_setup = psel_in && penable_in && !pready_out;
  assign apb_take = psel_in && penable_in && pready_out;
  assign cmd_wr = apb_take && pwrite_in && (paddr_in == afe_pkg::CMD_OFS);
  assign req_op = afe_pkg::afe_op_t'(pwdata_in[2:0]);
  assign op_ok = (req_op == afe_pkg::AFE_OP_WRITE) || (req_op == afe_pkg::AFE_OP_READ)
      || (req_op == afe_pkg::AFE_OP_RESET) || (req_op == afe_pkg::AFE_OP_REWIND);
  // no strobe while the flag blocks it, unless flow-through is allowed
  always_comb begin
    refuse = 1'b0;
    if (busy_r || !op_ok) begin
      refuse = 1'b1;
    end else if (req_op == afe_pkg::AFE_OP_WRITE && !full_s && !flow_r) begin
      refuse = 1'b1;
    end else if (req_op == afe_pkg::AFE_OP_READ && !empty_s && !flow_r) begin
      refuse = 1'b1;
    end
  end

  // command launch; low length chosen per operation, high length fixed
  always_comb begin
    seq.start = cmd_wr && !refuse;
    seq.high_len = 5'(afe_pkg::RECOVER_CYC);
    unique case (req_op)
      afe_pkg::AFE_OP_READ: seq.low_len = 5'(afe_pkg::READ_LOW_CYC);
      afe_pkg::AFE_OP_RESET: seq.low_len = 5'(afe_pkg::RESET_LOW_CYC);
      afe_pkg::AFE_OP_REWIND: seq.low_len = 5'(afe_pkg::REWIND_LOW_CYC);
      default: seq.low_len = 5'(afe_pkg::STROBE_LOW_CYC);
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_r <= 1'b0;
      op_r <= afe_pkg::AFE_OP_NONE;
    end else if (seq.start) begin
      busy_r <= 1'b1;
      op_r <= req_op;
    end else if (seq.done) begin
      busy_r <= 1'b0;
      op_r <= afe_pkg::AFE_OP_NONE;
    end
  end

  // one strobe at a time; the other strobes stay high meanwhile
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      write_strobe_n_out <= 1'b1;
      read_strobe_n_out <= 1'b1;
      reset_n_out <= 1'b1;
      rewind_strobe_n_out <= 1'b1;
    end else if (seq.start) begin
      write_strobe_n_out <= !(req_op == afe_pkg::AFE_OP_WRITE);
      read_strobe_n_out <= !(req_op == afe_pkg::AFE_OP_READ);
      reset_n_out <= !(req_op == afe_pkg::AFE_OP_RESET);
      rewind_strobe_n_out <= !(req_op == afe_pkg::AFE_OP_REWIND);
    end else if (seq.last_low) begin
      write_strobe_n_out <= 1'b1;
      read_strobe_n_out <= 1'b1;
      reset_n_out <= 1'b1;
      rewind_strobe_n_out <= 1'b1;
    end
  end

  // single-device use only; no ring, no first-device select
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      chain_input_out <= 1'b0;
    end else begin
      chain_input_out <= 1'b0;
    end
  end

  // write data held on the pins for the whole strobe
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fifo_d_out <= afe_pkg::WDATA_RST;
    end else if (apb_take && pwrite_in && paddr_in == afe_pkg::WDATA_OFS && !busy_r) begin
      fifo_d_out <= pwdata_in[8:0];
    end
  end

  // read word caught at the end of the low phase, access plus sync covered
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_r <= 9'h000;
      rdvalid_r <= 1'b0;
    end else if (seq.last_low && op_r == afe_pkg::AFE_OP_READ) begin
      rdata_r <= sync2_r[8:0];
      rdvalid_r <= 1'b1;
    end else if (apb_take && !pwrite_in && paddr_in == afe_pkg::RDATA_OFS) begin
      rdvalid_r <= 1'b0;
    end
  end

  // refusal is sticky; a new refusal beats the clear
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= (cmd_wr && refuse) || (refused_r && !(apb_take && pwrite_in
          && paddr_in == afe_pkg::STATUS_OFS && pwdata_in[afe_pkg::ST_REFUSED]));
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flow_r <= 1'b0;
    end else if (apb_take && pwrite_in && paddr_in == afe_pkg::CONFIG_OFS) begin
      flow_r <= pwdata_in[afe_pkg::CFG_FLOW];
    end
  end

  // apb answer: one wait state, data and error registered with pready
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= apb_setup;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      if (apb_setup) begin
        unique case (paddr_in)
          afe_pkg::CMD_OFS: prdata_out <= {29'h0000_0000, op_r};
          afe_pkg::WDATA_OFS: prdata_out <= {23'h00_0000, fifo_d_out};
          afe_pkg::STATUS_OFS: prdata_out <= {26'h000_0000, rdvalid_r, refused_r,
              half_s, full_s, empty_s, busy_r};
          afe_pkg::RDATA_OFS: prdata_out <= {23'h00_0000, rdata_r};
          afe_pkg::CONFIG_OFS: prdata_out <= {31'h0000_0000, flow_r};
          default: pslverr_out <= 1'b1;
        endcase
      end
    end
  end

  // checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  logic [4:0] wr_low_cnt_r;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_low_cnt_r <= 5'h00;
    end else if (!write_strobe_n_out) begin
      wr_low_cnt_r <= wr_low_cnt_r + 5'h01;
    end else begin
      wr_low_cnt_r <= 5'h00;
    end
  end

  sequence s_read_start;
    $fell(read_strobe_n_out);
  endsequence
  sequence s_read_hold;
    !read_strobe_n_out [*8] ##[1:20] read_strobe_n_out;
  endsequence

  property p_wr_flag;
    $fell(write_strobe_n_out) |-> ($past(full_s) || flow_r);
  endproperty
  a_wr_flag: assert property (p_wr_flag) else $error("write strobe while full");
  property p_rd_flag;
    $fell(read_strobe_n_out) |-> ($past(empty_s) || flow_r);
  endproperty
  a_rd_flag: assert property (p_rd_flag) else $error("read strobe while empty");
  property p_rewind_quiet;
    !rewind_strobe_n_out |-> write_strobe_n_out && read_strobe_n_out;
  endproperty
  a_rewind_quiet: assert property (p_rewind_quiet) else $error("strobe during rewind");
  property p_reset_quiet;
    !reset_n_out |-> write_strobe_n_out && read_strobe_n_out && rewind_strobe_n_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("strobe during reset");
  property p_chain;
    chain_input_out == 1'b0;
  endproperty
  a_chain: assert property (p_chain) else $error("chain input not grounded");
  property p_wr_len;
    $rose(write_strobe_n_out) |-> wr_low_cnt_r == 5'(afe_pkg::STROBE_LOW_CYC);
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe width wrong");
  property p_data_stable;
    !write_strobe_n_out && $past(!write_strobe_n_out) |-> $stable(fifo_d_out);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved in strobe");
  property p_rd_width;
    s_read_start |-> s_read_hold;
  endproperty
  a_rd_width: assert property (p_rd_width) else $error("read strobe width wrong");
  property p_rd_capture;
    $rose(read_strobe_n_out) |-> rdvalid_r && rdata_r == $past(sync2_r[8:0]);
  endproperty
  a_rd_capture: assert property (p_rd_capture) else $error("read word not caught");
endmodule
`default_nettype wire

//--- bench/afe_fifo_model.sv
`timescale 1ns/100ps
`default_nettype none
module afe_fifo_model #(
  parameter int DEPTH = afe_pkg::DEPTH,
  parameter int ACC_NS = 20
) (
  // writing side
  input wire logic [8:0] d_in,
  input wire logic write_strobe_n_in,
  // reading side
  input wire logic read_strobe_n_in,
  output logic [8:0] q_out,
  // control
  input wire logic reset_n_in,
  input wire logic rewind_strobe_n_in,
  input wire logic chain_input_in,
  // flags
  output logic empty_indicator_n_out,
  output logic full_indicator_n_out,
  output logic half_full_indicator_n_out
);
  logic [8:0] mem [DEPTH];
  int wptr = 0;
  int rptr = 0;
  int cnt = 0;
  logic wr_ok = 1'b0;
  logic rd_ok = 1'b0;
  logic wr_wait = 1'b0;
  logic rd_wait = 1'b0;
  initial q_out = 9'h155;
  always @(negedge reset_n_in) begin
    wptr = 0;
    rptr = 0;
    cnt = 0;
  end
  // count rebuilt from write pointer: valid only before any wrap
  always @(negedge rewind_strobe_n_in) if (reset_n_in) begin
    rptr = 0;
    cnt = wptr;
  end
  always @(negedge write_strobe_n_in) begin
    wr_ok = reset_n_in && cnt < DEPTH;
    wr_wait = reset_n_in && !wr_ok;
  end
  always @(posedge write_strobe_n_in) begin
    if (wr_ok) begin
      mem[wptr] = d_in;
      wptr = (wptr + 1) % DEPTH;
      cnt++;
      wr_ok = 1'b0;
    end
    wr_wait = 1'b0;
    // read held low through the first write sees that one word
    if (rd_wait && !read_strobe_n_in && cnt > 0) begin
      rd_wait = 1'b0;
      rd_ok = 1'b1;
      #(ACC_NS);
      if (!read_strobe_n_in) q_out = mem[rptr];
    end
  end
  always @(negedge read_strobe_n_in) begin
    rd_ok = reset_n_in && cnt > 0;
    rd_wait = reset_n_in && !rd_ok;
    #(ACC_NS);
    if (rd_ok && !read_strobe_n_in) q_out = mem[rptr];
  end
  // released bus shows the inverse, never the last word
  always @(posedge read_strobe_n_in) begin
    if (rd_ok) begin
      rptr = (rptr + 1) % DEPTH;
      cnt--;
      rd_ok = 1'b0;
    end
    rd_wait = 1'b0;
    // write held low across a read from full stores one word
    if (wr_wait && !write_strobe_n_in && cnt < DEPTH) begin
      wr_wait = 1'b0;
      wr_ok = 1'b1;
    end
    #10;
    q_out = ~q_out;
  end
  // empty releases briefly in read flow-through, then sets again
  assign empty_indicator_n_out = (cnt != 0);
  // a held write into the last slot sets full early
  assign full_indicator_n_out = !(cnt == DEPTH
      || (cnt == DEPTH - 1 && wr_ok && !write_strobe_n_in));
  assign half_full_indicator_n_out = chain_input_in | (cnt <= DEPTH / 2);
endmodule
`default_nettype wire

//--- bench/async_fifo_expansion_modes_test.sv
`timescale 1ns/100ps
`default_nettype none
module async_fifo_expansion_modes_test;
  logic clk_in, resetn_in, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [8:0] d, q;
  logic wr_n, rd_n, rst_n, rw_n, chain, empty_n, full_n, half_n;
  int n_errors = 0;
  int samples_checked = 0;
  afe_host_ctrl u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .fifo_d_out(d),
    .write_strobe_n_out(wr_n), .read_strobe_n_out(rd_n), .reset_n_out(rst_n),
    .rewind_strobe_n_out(rw_n), .chain_input_out(chain), .fifo_q_in(q),
    .empty_indicator_n_in(empty_n), .full_indicator_n_in(full_n),
    .half_full_indicator_n_in(half_n));
  afe_fifo_model #(.DEPTH(8), .ACC_NS(afe_pkg::READ_ACCESS_NS)) u_model (.d_in(d),
    .write_strobe_n_in(wr_n),
    .read_strobe_n_in(rd_n), .q_out(q), .reset_n_in(rst_n), .rewind_strobe_n_in(rw_n),
    .chain_input_in(chain), .empty_indicator_n_out(empty_n),
    .full_indicator_n_out(full_n), .half_full_indicator_n_out(half_n));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb_answer", 32'h1, {31'h0, pready});
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, v, r, e);
    chk("slverr", 32'h0, {31'h0, e});
  endtask
  task automatic rd32(input logic [7:0] a, output logic [31:0] v);
    logic e;
    apb(1'b0, a, 32'h0, v, e);
    chk("slverr", 32'h0, {31'h0, e});
  endtask
  task automatic op(input afe_pkg::afe_op_t c);
    logic [31:0] s;
    int n;
    n = 0;
    wr32(afe_pkg::CMD_OFS, {29'h0, c});
    do begin
      rd32(afe_pkg::STATUS_OFS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 40);
    chk("op_done", 32'h0, {31'h0, s[0]});
  endtask
  task automatic chk_st(input string what, input logic e_n, f_n, h_n, rf);
    logic [31:0] s;
    rd32(afe_pkg::STATUS_OFS, s);
    chk(what, {26'h0, 1'b0, rf, h_n, f_n, e_n, 1'b0}, s & 32'h3F);
    if (rf) wr32(afe_pkg::STATUS_OFS, 32'h10);
  endtask
  task automatic put(input logic [8:0] v);
    wr32(afe_pkg::WDATA_OFS, {23'h0, v});
    op(afe_pkg::AFE_OP_WRITE);
  endtask
  task automatic get(input logic [8:0] v);
    logic [31:0] r;
    op(afe_pkg::AFE_OP_READ);
    rd32(afe_pkg::STATUS_OFS, r);
    chk("rdvalid", 32'h1, {31'h0, r[afe_pkg::ST_RDVALID]});
    rd32(afe_pkg::RDATA_OFS, r);
    chk("rdata", {23'h0, v}, r);
  endtask
  task automatic t_reset();
    chk("idle_pins", 32'h1E, {27'h0, wr_n, rd_n, rst_n, rw_n, chain});
    op(afe_pkg::AFE_OP_RESET);
    chk_st("after_reset", 1'b0, 1'b1, 1'b1, 1'b0);
  endtask
  task automatic t_fill_drain();
    for (int i = 0; i < 8; i++) begin
      put(9'h1A5 ^ 9'(i));
      chk_st("fill", 1'b1, i != 7, i < 4, 1'b0);
    end
    put(9'h0FF);
    chk_st("full_refused", 1'b1, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) get(9'h1A5 ^ 9'(i));
    chk_st("drained", 1'b0, 1'b1, 1'b1, 1'b0);
    op(afe_pkg::AFE_OP_READ);
    chk_st("empty_refused", 1'b0, 1'b1, 1'b1, 1'b1);
    put(9'h0AA);
    put(9'h155);
    get(9'h0AA);
    get(9'h155);
  endtask
  task automatic t_rewind();
    op(afe_pkg::AFE_OP_RESET);
    put(9'h011);
    put(9'h022);
    get(9'h011);
    op(afe_pkg::AFE_OP_REWIND);
    get(9'h011);
    get(9'h022);
  endtask
  task automatic t_flow();
    logic [31:0] r;
    op(afe_pkg::AFE_OP_RESET);
    wr32(afe_pkg::CONFIG_OFS, 32'h1);
    rd32(afe_pkg::CONFIG_OFS, r);
    chk("config", 32'h1, r);
    op(afe_pkg::AFE_OP_READ);
    rd32(afe_pkg::RDATA_OFS, r);
    chk_st("flow_read", 1'b0, 1'b1, 1'b1, 1'b0);
    wr32(afe_pkg::WDATA_OFS, 32'h0C3);
    wr32(afe_pkg::CMD_OFS, {29'h0, afe_pkg::AFE_OP_WRITE});
    rd32(afe_pkg::CMD_OFS, r);
    chk("cmd_busy", {29'h0, afe_pkg::AFE_OP_WRITE}, r);
    wr32(afe_pkg::WDATA_OFS, 32'h03C);
    rd32(afe_pkg::WDATA_OFS, r);
    chk("wdata_held", 32'h0C3, r);
    repeat (40) @(posedge clk_in);
    get(9'h0C3);
    for (int i = 0; i < 8; i++) put(9'h0F0 ^ 9'(i));
    put(9'h111);
    chk_st("flow_full", 1'b1, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) get(9'h0F0 ^ 9'(i));
    wr32(afe_pkg::CONFIG_OFS, 32'h0);
  endtask
  task automatic t_unmapped();
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
  endtask
  // strobes must sit high while device reset or rewind is low
  // sampled mid-cycle, where the registered pins have settled
  always @(negedge clk_in) begin
    if (resetn_in === 1'b1 && (rw_n === 1'b0 || rst_n === 1'b0)) begin
      chk("strobes_held", 32'h3, {30'h0, wr_n, rd_n});
    end
  end
  initial begin
    repeat (40000) @(posedge clk_in);
    n_errors++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    summarize();
  end
  initial begin
    resetn_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_fill_drain();
    t_rewind();
    t_flow();
    t_unmapped();
    summarize();
  end
endmodule
`default_nettype wire
